//--- design/sd_decim_filter.sv
// Sigma-delta decimation filter with per-setup configuration over APB
//
// Function
// - Offer sinc5 plus sinc1, sinc3, and enhanced 50/60 Hz filter types.
// - Filter type and rate come from the setup selected for the current channel.
// - Sinc5 plus sinc1 at 10 kSPS or below delivers every word settled.
// - Sinc5 always runs at 125 kSPS; sinc1 length and single-cycle skips set output rate.
// - Sinc3 settling is always three output periods.
// - Direct map bit turns the register into a sinc3 ratio, disabling other options.
// - Mapped rate is modulator rate over 32 times register bits 14 to 0.
// - Single-cycle settle bit drops unsettled words so period equals settling time.
// - Single-cycle bit ignored for settled sinc5 plus sinc1 or multiple channels.
// - Without single-cycle, sinc3 delivers every word; settling takes three periods.
// - Enhanced filters postfilter the sinc5 plus sinc1 path; software selects it.
// - Fastest enhanced setting gives 27.27 SPS with 36.67 ms settling.
// - Other enhanced settings: 25/40 ms, 20/50 ms, 16.667/60 ms.
//
// Our own choices: the APB register port and the register offsets.
`timescale 1ns/1ps
module sd_decim_filter (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst,
  // APB slave
  input wire filt_pkg::apb_req_t i_apb,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // Modulator stream pins
  input wire logic i_mod_clk,
  input wire logic i_mod_bit,
  // Setup of the channel being converted
  input wire logic [filt_pkg::SETUP_W-1:0] i_setup_sel,
  // Conversion result
  output logic [filt_pkg::RESULT_W-1:0] o_result,
  output logic o_result_valid
);

  localparam int S5_RATIO_W = $clog2(filt_pkg::SINC5_RATIO) + 1;
  localparam int S5_ACC_W = filt_pkg::SINC5_ORDER * S5_RATIO_W + 1;
  localparam int S3_ACC_W = filt_pkg::SINC3_ORDER * filt_pkg::SINC3_RATIO_W + 1;
  localparam int AVG_W = S5_ACC_W + filt_pkg::SINC1_LEN_W;

  ////////////////////////////////////////////////////////////////////////////
  // Modulator input synchronisers
  logic mclk_s1_q, mclk_s2_q, mclk_s3_q;
  logic mbit_s1_q, mbit_s2_q;
  logic mod_valid;

  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      mclk_s1_q <= 1'b0;
      mclk_s2_q <= 1'b0;
      mclk_s3_q <= 1'b0;
      mbit_s1_q <= 1'b0;
      mbit_s2_q <= 1'b0;
    end
    else
    begin
      mclk_s1_q <= i_mod_clk;
      mclk_s2_q <= mclk_s1_q;
      mclk_s3_q <= mclk_s2_q;
      mbit_s1_q <= i_mod_bit;
      mbit_s2_q <= mbit_s1_q;
    end
  end

  // Bit delayed by the same two stages as the clock, taken on its rising edge
  assign mod_valid = mclk_s2_q && !mclk_s3_q;

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [1:0] ctrl_q, ctrl_d;
  logic [filt_pkg::FCFG_W-1:0] fcfg_q [filt_pkg::NUM_SETUPS];
  logic [filt_pkg::FCFG_W-1:0] fcfg_d [filt_pkg::NUM_SETUPS];
  logic [31:0] prdata_q, prdata_d;
  logic pready_q, pready_d;
  logic pslverr_q, pslverr_d;
  logic [filt_pkg::RESULT_W-1:0] result_q, result_d;
  logic result_valid_q, result_valid_d;
  logic [filt_pkg::COUNT_W-1:0] count_q, count_d;
  logic [filt_pkg::SETUP_W-1:0] setup_q;
  logic [1:0] skip_cnt_q, skip_cnt_d;
  logic restart_q, restart_d;
  logic wr_en, rd_setup, addr_fcfg;
  logic [filt_pkg::SETUP_W-1:0] addr_idx;
  filt_pkg::filt_sel_t sel;

  assign wr_en = i_apb.psel && i_apb.penable && pready_q && i_apb.pwrite;
  assign rd_setup = i_apb.psel && !i_apb.penable;
  assign addr_fcfg = (i_apb.paddr >= filt_pkg::OFS_FCFG_BASE) &&
    (i_apb.paddr < filt_pkg::OFS_FCFG_BASE + 8'(4 * filt_pkg::NUM_SETUPS)) &&
    (i_apb.paddr[1:0] == 2'h0);
  assign addr_idx = filt_pkg::SETUP_W'((i_apb.paddr - filt_pkg::OFS_FCFG_BASE) >> 2);

  genvar s;
  generate
    for (s = 0; s < filt_pkg::NUM_SETUPS; s++)
    begin : g_fcfg
      always_comb
      begin
        fcfg_d[s] = fcfg_q[s];
        if (wr_en && addr_fcfg && addr_idx == s)
          fcfg_d[s] = i_apb.pwdata[filt_pkg::FCFG_W-1:0];
      end
      always_ff @(posedge i_ref_clk)
      begin
        if (i_rst)
          fcfg_q[s] <= filt_pkg::FCFG_RESET;
        else
          fcfg_q[s] <= fcfg_d[s];
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Decode of the active setup
  function automatic filt_pkg::filt_sel_t decode(
    input logic [filt_pkg::FCFG_W-1:0] cfg,
    input logic single_cyc,
    input logic multi_ch
  );
    filt_pkg::filt_sel_t r;
    logic [filt_pkg::SINC1_LEN_W-1:0] odr_len;
    logic [1:0] enh;
    odr_len = filt_pkg::SINC1_LEN_W'(1) << cfg[filt_pkg::FCFG_ODR_LSB +: filt_pkg::FCFG_ODR_W];
    enh = cfg[filt_pkg::FCFG_ENH_LSB +: 2];
    r.kind = filt_pkg::FILT_SINC5_SINC1;
    r.sinc1_len = odr_len;
    r.sinc3_ratio = filt_pkg::SINC3_RATIO_W'(filt_pkg::SINC5_RATIO) * {7'h00, odr_len};
    r.skip = 2'h0;
    if (cfg[filt_pkg::FCFG_MAP_BIT])
    begin
      r.kind = filt_pkg::FILT_SINC3;
      r.sinc3_ratio = filt_pkg::SINC3_RATIO_W'(filt_pkg::SINC3_MAP_MULT) *
        {5'h00, cfg[filt_pkg::FCFG_RATIO_W-1:0]};
    end
    else if (cfg[filt_pkg::FCFG_ENH_EN_BIT])
    begin
      // Postfilter fed by sinc5 words; one period is one settling time
      r.kind = filt_pkg::FILT_ENHANCED;
      unique case (enh)
        2'h0: r.sinc1_len = filt_pkg::SINC1_LEN_W'(filt_pkg::ENH_LEN_0);
        2'h1: r.sinc1_len = filt_pkg::SINC1_LEN_W'(filt_pkg::ENH_LEN_1);
        2'h2: r.sinc1_len = filt_pkg::SINC1_LEN_W'(filt_pkg::ENH_LEN_2);
        2'h3: r.sinc1_len = filt_pkg::SINC1_LEN_W'(filt_pkg::ENH_LEN_3);
      endcase
    end
    else if (cfg[filt_pkg::FCFG_ORDER_LSB +: 2] != 2'h0)
      r.kind = filt_pkg::FILT_SINC3;
    // Single-cycle mode only when one channel runs and the path is not settled
    if (single_cyc && !multi_ch)
    begin
      if (r.kind == filt_pkg::FILT_SINC3)
        r.skip = 2'(filt_pkg::SINC3_SETTLE_PERIODS - 1);
      else if (r.kind == filt_pkg::FILT_SINC5_SINC1 &&
               r.sinc1_len < filt_pkg::SINC1_LEN_W'(filt_pkg::SINC1_SETTLED_LEN))
        r.skip = 2'h1;
    end
    return r;
  endfunction

  assign sel = decode(fcfg_q[i_setup_sel], ctrl_q[filt_pkg::CTRL_SINGLE_CYC_BIT],
    ctrl_q[filt_pkg::CTRL_MULTI_CH_BIT]);

  ////////////////////////////////////////////////////////////////////////////
  // Filter datapath
  logic [S5_ACC_W-1:0] s5_data;
  logic s5_valid;
  logic [AVG_W-1:0] avg_sum;
  logic avg_valid;
  logic [S3_ACC_W-1:0] s3_data;
  logic s3_valid;

  // Sinc5 ratio is fixed so its rate never depends on the setup
  cic_decim #(
    .ORDER(filt_pkg::SINC5_ORDER),
    .RATIO_W(S5_RATIO_W),
    .ACC_W(S5_ACC_W)
  ) u_sinc5 (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_restart(restart_q),
    .i_in_valid(mod_valid),
    .i_in_bit(mbit_s2_q),
    .i_ratio(S5_RATIO_W'(filt_pkg::SINC5_RATIO)),
    .o_data(s5_data),
    .o_valid(s5_valid)
  );

  boxcar_avg #(
    .IN_W(S5_ACC_W),
    .LEN_W(filt_pkg::SINC1_LEN_W)
  ) u_sinc1 (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_restart(restart_q),
    .i_in_valid(s5_valid),
    .i_in_data(s5_data),
    .i_len(sel.sinc1_len),
    .o_sum(avg_sum),
    .o_valid(avg_valid)
  );

  cic_decim #(
    .ORDER(filt_pkg::SINC3_ORDER),
    .RATIO_W(filt_pkg::SINC3_RATIO_W),
    .ACC_W(S3_ACC_W)
  ) u_sinc3 (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_restart(restart_q),
    .i_in_valid(mod_valid),
    .i_in_bit(mbit_s2_q),
    .i_ratio(sel.sinc3_ratio),
    .o_data(s3_data),
    .o_valid(s3_valid)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Output selection and settling
  logic raw_valid;
  logic [filt_pkg::RESULT_W-1:0] raw_word;

  always_comb
  begin
    raw_valid = avg_valid;
    raw_word = avg_sum[AVG_W-1 -: filt_pkg::RESULT_W];
    if (sel.kind == filt_pkg::FILT_SINC3)
    begin
      raw_valid = s3_valid;
      raw_word = s3_data[S3_ACC_W-1 -: filt_pkg::RESULT_W];
    end
  end

  always_comb
  begin
    restart_d = (i_setup_sel != setup_q) || (wr_en && (addr_fcfg ||
      i_apb.paddr == filt_pkg::OFS_CTRL));
    skip_cnt_d = skip_cnt_q;
    result_d = result_q;
    result_valid_d = 1'b0;
    count_d = count_q;
    if (restart_q)
      skip_cnt_d = 2'h0;
    else if (raw_valid)
    begin
      // Unsettled words are dropped, stretching the output period
      if (skip_cnt_q >= sel.skip)
      begin
        skip_cnt_d = 2'h0;
        result_d = raw_word;
        result_valid_d = 1'b1;
        count_d = count_q + 1'b1;
      end
      else
        skip_cnt_d = skip_cnt_q + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB slave: zero wait states, unmapped reads return zero with an error
  always_comb
  begin
    ctrl_d = ctrl_q;
    if (wr_en && i_apb.paddr == filt_pkg::OFS_CTRL)
      ctrl_d = i_apb.pwdata[1:0];
    pready_d = rd_setup;
    prdata_d = 32'h0000_0000;
    pslverr_d = 1'b0;
    if (rd_setup)
    begin
      if (addr_fcfg)
        prdata_d = {16'h0000, fcfg_q[addr_idx]};
      else if (i_apb.paddr == filt_pkg::OFS_CTRL)
        prdata_d = {30'h0, ctrl_q};
      else if (i_apb.paddr == filt_pkg::OFS_STATUS)
      begin
        prdata_d[filt_pkg::STAT_KIND_LSB +: 2] = sel.kind;
        prdata_d[filt_pkg::STAT_SKIP_LSB +: 2] = sel.skip;
        prdata_d[filt_pkg::STAT_SETUP_LSB +: filt_pkg::SETUP_W] = i_setup_sel;
        prdata_d[filt_pkg::STAT_COUNT_LSB +: filt_pkg::COUNT_W] = count_q;
      end
      else if (i_apb.paddr == filt_pkg::OFS_DATA)
        prdata_d = {8'h00, result_q};
      else
        pslverr_d = 1'b1;
    end
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      ctrl_q <= filt_pkg::CTRL_RESET;
      prdata_q <= 32'h0000_0000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      result_q <= '0;
      result_valid_q <= 1'b0;
      count_q <= '0;
      setup_q <= '0;
      skip_cnt_q <= 2'h0;
      restart_q <= 1'b1;
    end
    else
    begin
      ctrl_q <= ctrl_d;
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      result_q <= result_d;
      result_valid_q <= result_valid_d;
      count_q <= count_d;
      setup_q <= i_setup_sel;
      skip_cnt_q <= skip_cnt_d;
      restart_q <= restart_d;
    end
  end

  assign o_prdata = prdata_q;
  assign o_pready = pready_q;
  assign o_pslverr = pslverr_q;
  assign o_result = result_q;
  assign o_result_valid = result_valid_q;

endmodule

//--- inc/filt_pkg.sv
// Shared constants and types for the sigma-delta decimation filter
package filt_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // APB register map (byte addresses)
  localparam int APB_AW = 8;
  localparam logic [APB_AW-1:0] OFS_CTRL = 8'h00;
  localparam logic [APB_AW-1:0] OFS_STATUS = 8'h04;
  localparam logic [APB_AW-1:0] OFS_DATA = 8'h08;
  localparam logic [APB_AW-1:0] OFS_FCFG_BASE = 8'h20;
  localparam int NUM_SETUPS = 8;
  localparam int SETUP_W = 3;

  // Control register fields
  localparam int CTRL_SINGLE_CYC_BIT = 0;
  localparam int CTRL_MULTI_CH_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h0;

  // Filter configuration register fields
  localparam int FCFG_W = 16;
  localparam int FCFG_MAP_BIT = 15;
  localparam int FCFG_RATIO_W = 15;
  localparam int FCFG_ENH_EN_BIT = 11;
  localparam int FCFG_ENH_LSB = 8;
  localparam int FCFG_ORDER_LSB = 5;
  localparam int FCFG_ODR_LSB = 0;
  localparam int FCFG_ODR_W = 4;
  localparam logic [FCFG_W-1:0] FCFG_RESET = 16'h000A;

  // Status register fields
  localparam int STAT_KIND_LSB = 0;
  localparam int STAT_SKIP_LSB = 2;
  localparam int STAT_SETUP_LSB = 4;
  localparam int STAT_COUNT_LSB = 16;

  ////////////////////////////////////////////////////////////////////////////
  // Rates and filter figures
  localparam int MOD_RATE_HZ = 4000000;
  localparam int SINC5_ORDER = 5;
  localparam int SINC3_ORDER = 3;
  localparam int SINC5_RATIO = 32;
  localparam int SINC5_RATE_SPS = MOD_RATE_HZ / SINC5_RATIO;
  localparam int SINGLE_CYC_MAX_SPS = 10000;
  localparam int SINC1_SETTLED_LEN =
    (SINC5_RATE_SPS + SINGLE_CYC_MAX_SPS - 1) / SINGLE_CYC_MAX_SPS;
  localparam int SINC3_SETTLE_PERIODS = 3;
  localparam int SINC3_MAP_MULT = 32;
  localparam int SINC3_RATIO_W = 20;
  localparam int SINC1_LEN_W = 13;

  // Enhanced rejection settling times; each output period equals one of them
  localparam int ENH_SETTLE_US_0 = 36670;
  localparam int ENH_SETTLE_US_1 = 40000;
  localparam int ENH_SETTLE_US_2 = 50000;
  localparam int ENH_SETTLE_US_3 = 60000;
  localparam int ENH_LEN_0 = (ENH_SETTLE_US_0 * 125 + 500) / 1000;
  localparam int ENH_LEN_1 = (ENH_SETTLE_US_1 * 125 + 500) / 1000;
  localparam int ENH_LEN_2 = (ENH_SETTLE_US_2 * 125 + 500) / 1000;
  localparam int ENH_LEN_3 = (ENH_SETTLE_US_3 * 125 + 500) / 1000;

  localparam int RESULT_W = 24;
  localparam int COUNT_W = 16;

  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef enum logic [1:0] {
    FILT_SINC5_SINC1 = 2'b00,
    FILT_SINC3 = 2'b01,
    FILT_ENHANCED = 2'b11
  } filt_kind_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [APB_AW-1:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    filt_kind_t kind;
    logic [SINC1_LEN_W-1:0] sinc1_len;
    logic [SINC3_RATIO_W-1:0] sinc3_ratio;
    logic [1:0] skip;
  } filt_sel_t;

endpackage

//--- design/cic_decim.sv
// Runtime-ratio sinc (CIC) decimator on a one-bit modulator stream
`timescale 1ns/1ps
module cic_decim #(
  parameter int ORDER = 3,
  parameter int RATIO_W = 20,
  parameter int ACC_W = 61
) (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst,
  // Stream in
  input wire logic i_restart,
  input wire logic i_in_valid,
  input wire logic i_in_bit,
  input wire logic [RATIO_W-1:0] i_ratio,
  // Decimated out
  output logic [ACC_W-1:0] o_data,
  output logic o_valid
);

  // Refused at elaboration: a narrower accumulator would wrap inside one output word
  if (ORDER < 1 || ACC_W < ORDER * RATIO_W + 1)
  begin : g_bad_width
    $error("cic_decim: accumulator too narrow for order and ratio");
  end

  logic [ACC_W-1:0] integ_q [ORDER];
  logic [ACC_W-1:0] integ_d [ORDER];
  logic [ACC_W-1:0] dly_q [ORDER];
  logic [ACC_W-1:0] dly_d [ORDER];
  logic [ACC_W-1:0] comb [ORDER+1];
  logic [RATIO_W-1:0] cnt_q, cnt_d;
  logic [ACC_W-1:0] data_q, data_d;
  logic valid_q, valid_d;
  logic dump;

  // Ratio below one acts as one
  assign dump = i_in_valid && (cnt_q + 1'b1 >= i_ratio);
  assign comb[0] = integ_q[ORDER-1];

  genvar g;
  generate
    for (g = 0; g < ORDER; g++)
    begin : g_stage
      logic [ACC_W-1:0] feed;
      if (g == 0)
      begin : g_first
        assign feed = {{(ACC_W-1){1'b0}}, i_in_bit};
      end
      else
      begin : g_next
        assign feed = integ_q[g-1];
      end
      assign comb[g+1] = comb[g] - dly_q[g];
      always_comb
      begin
        integ_d[g] = integ_q[g];
        dly_d[g] = dly_q[g];
        if (i_restart)
        begin
          integ_d[g] = '0;
          dly_d[g] = '0;
        end
        else
        begin
          if (i_in_valid)
            integ_d[g] = integ_q[g] + feed;
          if (dump)
            dly_d[g] = comb[g];
        end
      end
      always_ff @(posedge i_ref_clk)
      begin
        if (i_rst)
        begin
          integ_q[g] <= '0;
          dly_q[g] <= '0;
        end
        else
        begin
          integ_q[g] <= integ_d[g];
          dly_q[g] <= dly_d[g];
        end
      end
    end
  endgenerate

  always_comb
  begin
    cnt_d = cnt_q;
    data_d = data_q;
    valid_d = 1'b0;
    if (i_restart)
      cnt_d = '0;
    else if (dump)
    begin
      cnt_d = '0;
      data_d = comb[ORDER];
      valid_d = 1'b1;
    end
    else if (i_in_valid)
      cnt_d = cnt_q + 1'b1;
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      cnt_q <= '0;
      data_q <= '0;
      valid_q <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      data_q <= data_d;
      valid_q <= valid_d;
    end
  end

  assign o_data = data_q;
  assign o_valid = valid_q;

endmodule

//--- design/boxcar_avg.sv
// Sinc1 averager: sums a runtime number of input words per output
`timescale 1ns/1ps
module boxcar_avg #(
  parameter int IN_W = 26,
  parameter int LEN_W = 13
) (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst,
  // Words in
  input wire logic i_restart,
  input wire logic i_in_valid,
  input wire logic [IN_W-1:0] i_in_data,
  input wire logic [LEN_W-1:0] i_len,
  // Sums out
  output logic [IN_W+LEN_W-1:0] o_sum,
  output logic o_valid
);

  if (IN_W < 1 || LEN_W < 1)
  begin : g_bad_width
    $error("boxcar_avg: widths must be positive");
  end

  logic [IN_W+LEN_W-1:0] acc_q, acc_d, sum_q, sum_d, acc_next;
  logic [LEN_W-1:0] cnt_q, cnt_d;
  logic valid_q, valid_d;

  assign acc_next = acc_q + {{LEN_W{1'b0}}, i_in_data};

  always_comb
  begin
    acc_d = acc_q;
    cnt_d = cnt_q;
    sum_d = sum_q;
    valid_d = 1'b0;
    if (i_restart)
    begin
      acc_d = '0;
      cnt_d = '0;
    end
    else if (i_in_valid)
    begin
      if (cnt_q + 1'b1 >= i_len)
      begin
        sum_d = acc_next;
        valid_d = 1'b1;
        acc_d = '0;
        cnt_d = '0;
      end
      else
      begin
        acc_d = acc_next;
        cnt_d = cnt_q + 1'b1;
      end
    end
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      acc_q <= '0;
      cnt_q <= '0;
      sum_q <= '0;
      valid_q <= 1'b0;
    end
    else
    begin
      acc_q <= acc_d;
      cnt_q <= cnt_d;
      sum_q <= sum_d;
      valid_q <= valid_d;
    end
  end

  assign o_sum = sum_q;
  assign o_valid = valid_q;

endmodule

//--- verif/sd_decim_filter_assertions.sv
// Concurrent port checks for the sigma-delta decimation filter
`timescale 1ns/1ps
module sd_decim_filter_assertions (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst,
  // APB
  input wire filt_pkg::apb_req_t i_apb,
  input wire logic [31:0] o_prdata,
  input wire logic o_pready,
  input wire logic o_pslverr,
  // Stream
  input wire logic i_mod_clk,
  input wire logic i_mod_bit,
  input wire logic [filt_pkg::SETUP_W-1:0] i_setup_sel,
  input wire logic [filt_pkg::RESULT_W-1:0] o_result,
  input wire logic o_result_valid
);
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_rst);

  logic hit;
  logic unmapped;
  assign hit = i_apb.psel && i_apb.penable && o_pready;
  assign unmapped = !(i_apb.paddr inside {8'h00, 8'h04, 8'h08}) &&
    !(i_apb.paddr >= 8'h20 && i_apb.paddr <= 8'h3C && i_apb.paddr[1:0] == 2'h0);

  ////////////////////////////////////////////////////////////////////////////
  sequence s_setup;
    i_apb.psel && !i_apb.penable;
  endsequence
  sequence s_quiet;
    !o_result_valid [*8];
  endsequence

  property p_ready_after_setup;
    s_setup |=> o_pready;
  endproperty
  property p_ready_cause;
    o_pready |-> i_apb.psel && i_apb.penable && $past(i_apb.psel && !i_apb.penable);
  endproperty
  property p_ready_pulse;
    o_pready |=> !o_pready;
  endproperty
  property p_err_unmapped;
    hit |-> o_pslverr == unmapped;
  endproperty
  property p_err_data;
    hit && o_pslverr |-> o_prdata == 32'h0;
  endproperty
  property p_ctrl_width;
    hit && !i_apb.pwrite && i_apb.paddr == filt_pkg::OFS_CTRL |-> o_prdata[31:2] == 30'h0;
  endproperty
  property p_kind_code;
    hit && !i_apb.pwrite && i_apb.paddr == filt_pkg::OFS_STATUS |-> o_prdata[1:0] != 2'h2;
  endproperty
  property p_valid_pulse;
    o_result_valid |=> s_quiet;
  endproperty
  property p_result_hold;
    !o_result_valid |-> $stable(o_result);
  endproperty
  property p_restart_quiet;
    hit && i_apb.pwrite && i_apb.paddr == filt_pkg::OFS_CTRL |=> ##2 s_quiet;
  endproperty

  a_ready_after_setup: assert property (p_ready_after_setup)
    else $error("pready missing after setup");
  a_ready_cause: assert property (p_ready_cause)
    else $error("pready without request");
  a_ready_pulse: assert property (p_ready_pulse)
    else $error("pready longer than one cycle");
  a_err_unmapped: assert property (p_err_unmapped)
    else $error("pslverr does not match address map");
  a_err_data: assert property (p_err_data)
    else $error("read data not zero on error");
  a_ctrl_width: assert property (p_ctrl_width)
    else $error("control register unused bits set");
  a_kind_code: assert property (p_kind_code)
    else $error("illegal filter kind code");
  a_valid_pulse: assert property (p_valid_pulse)
    else $error("result valid too close");
  a_result_hold: assert property (p_result_hold)
    else $error("result changed without valid");
  a_restart_quiet: assert property (p_restart_quiet)
    else $error("word delivered right after restart");
endmodule

//--- verif/mod_model.sv
// Behavioural sigma-delta modulator driving the filter's bitstream pins
`timescale 1ns/1ps
module mod_model #(
  parameter real HALF_NS = 125.0
) (
  // Control
  input wire logic i_run,
  input wire logic [7:0] i_level,
  // Stream pins
  output logic o_mod_clk,
  output logic o_mod_bit
);
  logic [8:0] acc;
  initial
  begin
    o_mod_clk = 1'b0;
    o_mod_bit = 1'b0;
    acc = 9'h000;
    forever
    begin
      // Half of a 4 MHz modulator period, free of the reference clock phase
      #(HALF_NS);
      o_mod_clk = i_run ? ~o_mod_clk : 1'b0;
      if (!o_mod_clk)
      begin
        // First-order loop: ones density follows the level; idle bit keeps toggling
        acc = {1'b0, acc[7:0]} + {1'b0, i_level};
        o_mod_bit = i_run ? acc[8] : ~o_mod_bit;
      end
    end
  end
endmodule

//--- verif/sd_decim_filter_tb_top.sv
// Self-checking bench for the sigma-delta decimation filter
`timescale 1ns/1ps
module sd_decim_filter_tb_top;
  typedef struct packed {logic [32:0] mask; logic [32:0] val;} note_t;
  logic clk;
  logic rst;
  filt_pkg::apb_req_t apb;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic mod_clk;
  logic mod_bit;
  logic [filt_pkg::SETUP_W-1:0] setup_sel;
  logic [filt_pkg::RESULT_W-1:0] result;
  logic result_valid;
  logic [7:0] level;
  logic [15:0] seed;
  note_t notes[$];
  note_t cur;
  int periods[$];
  int exp_gap;
  int gap;
  int n_errors;
  int n_checks;
  int cycles;

  sd_decim_filter sd_decim_filter_i (.i_ref_clk(clk), .i_rst(rst), .i_apb(apb),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_mod_clk(mod_clk),
    .i_mod_bit(mod_bit), .i_setup_sel(setup_sel), .o_result(result),
    .o_result_valid(result_valid));
  mod_model mod_model_i (.i_run(!rst), .i_level(level), .o_mod_clk(mod_clk),
    .o_mod_bit(mod_bit));

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [7:0] fcfg(input int n);
    return filt_pkg::OFS_FCFG_BASE + 8'(4 * n);
  endfunction

  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_sim();
    $display("Checks %0d, errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Entered just after a rising edge; holds the request until pready is sampled
  task automatic apb_xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
    input logic [32:0] m, input logic [32:0] v);
    notes.push_back('{m, v});
    apb <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
    @(posedge clk);
    apb.penable <= 1'b1;
    do
      @(posedge clk);
    while (pready !== 1'b1);
    apb <= '0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb_xfer(1'b1, a, d, 33'h1_0000_0000, 33'h0_0000_0000);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    apb_xfer(1'b0, a, 32'h0000_0000, {1'b1, m}, {1'b0, e & m});
  endtask

  // Skips the words unsettled by a restart, then notes one word spacing
  task automatic expect_period(input int p);
    repeat (2)
      do
        @(posedge clk);
      while (result_valid !== 1'b1);
    @(posedge clk);
    periods.push_back(p);
    do
      @(posedge clk);
    while (result_valid !== 1'b1);
    @(posedge clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Result watcher: spacing tolerates the two-flop sync of the modulator clock
  always @(posedge clk)
  begin
    cycles++;
    if (pready === 1'b1 && notes.size() > 0)
    begin
      cur = notes.pop_front();
      check({pslverr, prdata} & cur.mask, cur.val);
    end
    if (result_valid === 1'b1)
    begin
      if (periods.size() > 0)
      begin
        exp_gap = periods.pop_front();
        check(33'((gap >= exp_gap - 2 && gap <= exp_gap + 2) ? exp_gap : gap),
          33'(exp_gap));
      end
      gap = 1;
    end
    else
      gap++;
    // Kept last so that nothing in this process runs after the run ends
    if (cycles > 80000)
    begin
      n_errors++;
      end_sim();
    end
  end

  initial
  begin
    clk = 1'b0;
    forever
      #20 clk = ~clk;
  end

  initial
  begin
    rst = 1'b1;
    apb = '0;
    setup_sel = '0;
    seed = 16'h000E;
    level = 8'h60;
    n_errors = 0;
    n_checks = 0;
    cycles = 0;
    gap = 0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    seed = lfsr(seed);
    level <= seed[7:0];
    @(posedge clk);
    rd(filt_pkg::OFS_CTRL, 32'h0000_0000, 32'hFFFF_FFFF);
    rd(fcfg(0), 32'h0000_000A, 32'hFFFF_FFFF);
    apb_xfer(1'b0, 8'h10, 32'h0, {33{1'b1}}, {1'b1, 32'h0000_0000});
    for (int n = 2; n < filt_pkg::NUM_SETUPS; n++)
    begin
      seed = lfsr(seed);
      wr(fcfg(n), {16'h0000, seed});
      rd(fcfg(n), {16'h0000, seed}, 32'hFFFF_FFFF);
    end
    wr(fcfg(0), 32'h0000_0000);
    expect_period(200);
    rd(filt_pkg::OFS_DATA, 32'h0000_0000, 32'hFF00_0000);
    wr(filt_pkg::OFS_CTRL, 32'h0000_0001);
    rd(filt_pkg::OFS_STATUS, 32'h0000_0004, 32'h0000_000F);
    expect_period(400);
    wr(fcfg(0), 32'h0000_0004);
    expect_period(3200);
    wr(filt_pkg::OFS_CTRL, 32'h0000_0003);
    wr(fcfg(0), 32'h0000_0020);
    expect_period(200);
    wr(filt_pkg::OFS_CTRL, 32'h0000_0001);
    expect_period(600);
    wr(filt_pkg::OFS_CTRL, 32'h0000_0000);
    expect_period(200);
    wr(fcfg(0), 32'h0000_8009);
    rd(filt_pkg::OFS_STATUS, 32'h0000_0001, 32'h0000_0003);
    expect_period(1800);
    for (int e = 0; e < 4; e++)
    begin
      wr(fcfg(0), 32'h0000_0800 | (32'(e) << filt_pkg::FCFG_ENH_LSB));
      rd(filt_pkg::OFS_STATUS, 32'h0000_0003, 32'h0000_0003);
    end
    wr(fcfg(0), 32'h0000_0000);
    wr(fcfg(1), 32'h0000_0021);
    setup_sel <= 3'h1;
    @(posedge clk);
    rd(filt_pkg::OFS_STATUS, 32'h0000_0011, 32'h0000_0073);
    expect_period(400);
    end_sim();
  end
endmodule

bind sd_decim_filter sd_decim_filter_assertions sd_decim_filter_assertions_i (
  .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_apb(i_apb), .o_prdata(o_prdata),
  .o_pready(o_pready), .o_pslverr(o_pslverr), .i_mod_clk(i_mod_clk), .i_mod_bit(i_mod_bit),
  .i_setup_sel(i_setup_sel), .o_result(o_result), .o_result_valid(o_result_valid));
